// ---- host_xfer_defs.svh ----
// register offsets, field positions, reset values and sizes for the host transfer block
`ifndef HOST_XFER_DEFS_SVH
`define HOST_XFER_DEFS_SVH
`define OFS_PKT_PORT 8'h00
`define OFS_IRQ 8'h01
`define OFS_TWC_LO 8'h02
`define OFS_TWC_HI 8'h03
`define OFS_HEAD0 8'h04
`define OFS_HEAD3 8'h07
`define OFS_TAC_LO 8'h04
`define OFS_TAC_HI 8'h05
`define OFS_TRIGGER 8'h06
`define OFS_TRANSFER_END_ACKNOWLEDGE 8'h07
`define OFS_BIA_LO 8'h08
`define OFS_BIA_HI 8'h09
`define OFS_EIA_RD_LO 8'h08
`define OFS_EIA_RD_HI 8'h09
`define OFS_BAC_LO 8'h0A
`define OFS_BAC_HI 8'h0B
`define OFS_DECODER_CONTROL_ZERO 8'h0A
`define OFS_EIA_WR_LO 8'h0C
`define OFS_EIA_WR_HI 8'h0D
`define OFS_DIN_ACK 8'h0E
`define OFS_SEC_STAT 8'h0F
`define OFS_LSEC_STAT 8'h4B
`define OFS_TGT_STAT 8'h80
`define BIT_PFNE_EN 7
`define BIT_TEND_EN 6
`define BIT_SR_EN 5
`define BIT_TRANSFER_LOGIC_ENABLE 1
`define BIT_LINEAR 7
`define INTERRUPT_ENABLE_CONTROL_RST 8'h00
`define DECODER_CONTROL_ZERO_RST 8'h00
`define PKT_DEPTH 4'hC
`define PKT_EMPTY_VAL 8'hFF
`define BUF_STEP 16'h0002
`define BUF_SYNC_OFS 16'h000C
`define WORD_STEP 16'h0002
`endif

// ---- host_xfer_pkg.sv ----
// shared types of the host transfer block
`default_nettype none
package host_xfer_pkg;
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_REQ = 2'b01,
    FETCH_WAIT = 2'b10
  } fetch_state_t;
  typedef enum logic [1:0] {
    END_NONE = 2'b00,
    END_DATA_IN = 2'b01,
    END_DATA_OUT = 2'b10,
    END_PACKET = 2'b11
  } end_cause_t;
  typedef struct packed {
    logic valid;
    logic sub;
    logic [1:0] idx;
    logic [7:0] data;
  } hdr_byte_t;
  typedef struct packed {
    logic soft_reset;
    logic absent_slave;
    logic diagnostics;
    logic cmd_written;
    logic srst_bit;
  } host_evt_t;
endpackage
`default_nettype wire

// ---- host_transfer_irq_regs.sv ----
// host transfer, interrupt reason and header/buffering registers with the data FIFO
`timescale 1ns/1ps
`default_nettype none
`include "host_xfer_defs.svh"

module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointers and fill level; flush beats both sides
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        if (push && !pop) cnt_q <= cnt_q + 1'b1;
        else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  // storage needs no reset
  always_ff @(posedge clk) begin
    if (ce && push && !flush) mem_q[wr_q] <= in_data;
  end
endmodule // data_fifo

module host_transfer_irq_regs
  import host_xfer_pkg::*;
#(
  parameter int BLOCK_BYTES = 2048,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic host_rst,
  input wire logic fw_rst,
  input wire logic decoder_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic host_pkt_wr,
  input wire logic [7:0] host_pkt_data,
  input wire logic host_rd,
  input wire logic host_wr,
  output logic [15:0] host_rdata,
  input wire logic host_cmd_a0,
  input wire logic drive_selected,
  input wire host_evt_t host_evt,
  input wire host_evt_t host_evt_en,
  input wire logic auto_packet_enable,
  input wire logic auto_transfer_trigger,
  input wire logic data_out_direction,
  input wire logic data_fifo_reset,
  input wire logic sector_ready_remap,
  input wire logic sector_ready_evt,
  input wire logic [6:0] target_search_status,
  input wire logic subcode_irq_enable,
  input wire logic [2:0] subcode_status_reg,
  input wire logic subcode_acknowledge,
  input wire logic subheader_switch,
  input wire logic q_channel_time_load,
  input wire hdr_byte_t hdr_in,
  input wire hdr_byte_t q_in,
  input wire logic [15:0] linear_ram_address_counter,
  input wire logic [15:0] transfer_block_number,
  input wire logic [15:0] decoder_block_number,
  input wire logic data_sync,
  input wire logic buffer_word,
  output logic ram_rd_req,
  output logic [31:0] ram_addr,
  input wire logic ram_rd_valid,
  input wire logic [15:0] ram_rdata,
  output logic ram_port_blocked,
  output logic [15:0] buf_wr_addr,
  output logic [15:0] buf_block,
  output logic [15:0] ecc_block,
  output logic [7:0] decoder_control_zero,
  output logic data_fifo_ready_n,
  output logic transfer_busy_flag_n,
  output logic transfer_end_flag_n,
  output logic packet_full_flag,
  output logic transfer_direction_flag,
  output logic micro_irq_pin_n
);
  localparam logic [15:0] BLK_MASK = 16'(BLOCK_BYTES - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  logic any_rst, soft_rst;
  logic wr_trig, wr_transfer_end_acknowledge, wr_dinack, rd_irq, rd_pkt, rd_sec;
  logic [7:0] interrupt_enable_control_q;
  logic [11:0] twc_q;
  logic linear_q;
  logic [15:0] tac_q, bia_q, eia_q, bac_q, fetch_ofs_q;
  logic [12:0] fetch_left_q;
  logic pfne_q, tend_q, sr_q, hci_q, sci_q, busy_q, din_pend_q;
  logic [2:0] sub_prev_q;
  end_cause_t cause_q;
  fetch_state_t fst_q;
  logic [7:0] pkt_mem_q [12];
  logic [3:0] pkt_wr_q, pkt_rd_q;
  logic [31:0] head_q;
  logic [15:0] lo_half_q;
  logic half_in_q, half_out_q;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
  logic [31:0] fifo_out_data;
  logic data_in_end, data_out_end, pkt_full_evt, last_fetch, start_in, start_out;
  logic transfer_logic_enable;

  assign soft_rst = host_rst || fw_rst;
  assign any_rst = soft_rst || decoder_rst;
  // register strobes
  assign wr_trig = reg_wr && hit(reg_addr, `OFS_TRIGGER);
  assign wr_transfer_end_acknowledge = reg_wr && hit(reg_addr, `OFS_TRANSFER_END_ACKNOWLEDGE);
  assign wr_dinack = reg_wr && hit(reg_addr, `OFS_DIN_ACK);
  assign rd_irq = reg_rd && hit(reg_addr, `OFS_IRQ);
  assign rd_pkt = reg_rd && hit(reg_addr, `OFS_PKT_PORT);
  assign rd_sec = reg_rd && (hit(reg_addr, `OFS_SEC_STAT) || hit(reg_addr, `OFS_LSEC_STAT)
                  || hit(reg_addr, `OFS_TGT_STAT));
  assign transfer_logic_enable = interrupt_enable_control_q[`BIT_TRANSFER_LOGIC_ENABLE];
  // the auto trigger starts even while the enable bit it sets is still low
  assign start_in = (transfer_logic_enable || auto_transfer_trigger) && !soft_rst && !data_out_direction
                    && (wr_trig || auto_transfer_trigger);
  assign start_out = (transfer_logic_enable || auto_transfer_trigger) && !soft_rst && data_out_direction
                     && (wr_trig || auto_transfer_trigger);
  // host reads a word while a transfer runs; last word ends it
  assign fifo_pop = host_rd && busy_q && fifo_out_valid && (half_out_q || twc_q == 12'h000);
  assign data_in_end = host_rd && busy_q && !data_out_direction && twc_q == 12'h000;
  assign data_out_end = host_wr && busy_q && data_out_direction && twc_q == 12'h000;
  assign pkt_full_evt = host_pkt_wr && pkt_wr_q == `PKT_DEPTH - 4'h1;
  // fifo emptied on every documented cause; stale words never reach the host
  assign fifo_flush = any_rst || !transfer_logic_enable || data_out_direction || data_fifo_reset
                      || data_in_end;
  assign last_fetch = fetch_left_q == 13'h0001;

  // control register with transfer enable; hardware set beats any write, even one clearing the enable bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_enable_control_q <= `INTERRUPT_ENABLE_CONTROL_RST;
    end else if (ce) begin
      if (soft_rst) interrupt_enable_control_q <= `INTERRUPT_ENABLE_CONTROL_RST;
      else begin
        if (reg_wr && hit(reg_addr, `OFS_IRQ)) interrupt_enable_control_q <= reg_wdata;
        if (decoder_rst) interrupt_enable_control_q[`BIT_SR_EN] <= 1'b0;
        if (auto_transfer_trigger || (host_cmd_a0 && auto_packet_enable && drive_selected))
          interrupt_enable_control_q[`BIT_TRANSFER_LOGIC_ENABLE] <= 1'b1;
      end
    end
  end

  // word counter, linear select and offset counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      twc_q <= '0;
      linear_q <= 1'b0;
      tac_q <= '0;
    end else if (ce) begin
      if (soft_rst) begin
        twc_q <= '0;
        linear_q <= 1'b0;
        tac_q <= '0;
      end else if ((host_rd || host_wr) && busy_q && twc_q != 12'h000) begin
        twc_q <= twc_q - 12'h001;
        tac_q <= tac_q + `WORD_STEP;
      end else begin
        if (reg_wr && hit(reg_addr, `OFS_TWC_LO)) twc_q[7:0] <= reg_wdata;
        if (reg_wr && hit(reg_addr, `OFS_TWC_HI)) begin
          twc_q[11:8] <= reg_wdata[3:0];
          linear_q <= reg_wdata[`BIT_LINEAR];
        end
        if (reg_wr && hit(reg_addr, `OFS_TAC_LO)) tac_q[7:0] <= reg_wdata;
        if (reg_wr && hit(reg_addr, `OFS_TAC_HI)) tac_q[15:8] <= reg_wdata;
      end
    end
  end

  // busy flag and end cause; a transfer end sets flags even in the ack cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      tend_q <= 1'b0;
      din_pend_q <= 1'b0;
      cause_q <= END_NONE;
    end else if (ce) begin
      if (soft_rst) begin
        busy_q <= 1'b0;
        tend_q <= 1'b0;
        din_pend_q <= 1'b0;
        cause_q <= END_NONE;
      end else begin
        if (!transfer_logic_enable && !auto_transfer_trigger) busy_q <= 1'b0;
        else if (start_in || start_out) busy_q <= 1'b1;
        else if (data_in_end || data_out_end) busy_q <= 1'b0;
        if (data_in_end || data_out_end || pkt_full_evt) tend_q <= 1'b1;
        else if (wr_transfer_end_acknowledge && !din_pend_q) tend_q <= 1'b0;
        if (data_in_end) begin
          cause_q <= END_DATA_IN;
          din_pend_q <= 1'b1;
        end else begin
          if (data_out_end) cause_q <= END_DATA_OUT;
          if (pkt_full_evt) cause_q <= END_PACKET;
          if (wr_dinack) din_pend_q <= 1'b0;
        end
      end
    end
  end

  // RAM fetch engine: packs two words into one FIFO entry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fst_q <= FETCH_IDLE;
      fetch_left_q <= '0;
      fetch_ofs_q <= '0;
      half_in_q <= 1'b0;
      lo_half_q <= '0;
      ram_rd_req <= 1'b0;
      ram_addr <= '0;
    end else if (ce) begin
      ram_rd_req <= 1'b0;
      if (fifo_flush && !start_in) begin
        fst_q <= FETCH_IDLE;
        fetch_left_q <= '0;
        half_in_q <= 1'b0;
      end else if (start_in) begin
        fst_q <= FETCH_REQ;
        fetch_left_q <= {1'b0, twc_q} + 13'h0001;
        fetch_ofs_q <= linear_q ? linear_ram_address_counter : tac_q;
        half_in_q <= 1'b0;
      end else begin
        case (fst_q)
          FETCH_REQ: begin
            if (fifo_in_ready) begin
              ram_rd_req <= 1'b1;
              if (linear_q) ram_addr <= {16'h0000, fetch_ofs_q};
              else ram_addr <= transfer_block_number * 32'(BLOCK_BYTES)
                               + {16'h0000, fetch_ofs_q & BLK_MASK};
              fst_q <= FETCH_WAIT;
            end
          end
          FETCH_WAIT: begin
            if (ram_rd_valid) begin
              lo_half_q <= ram_rdata;
              half_in_q <= !half_in_q && !last_fetch;
              fetch_left_q <= fetch_left_q - 13'h0001;
              fetch_ofs_q <= fetch_ofs_q + `WORD_STEP;
              fst_q <= last_fetch ? FETCH_IDLE : FETCH_REQ;
            end
          end
          FETCH_IDLE: fst_q <= FETCH_IDLE;
          default: fst_q <= FETCH_IDLE;
        endcase
      end
    end
  end

  // entry is pushed on the high word or on an odd last word
  assign fifo_in_valid = ce && fst_q == FETCH_WAIT && ram_rd_valid && (half_in_q || last_fetch)
                         && !fifo_flush;

  data_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) i_data_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(half_in_q ? {ram_rdata, lo_half_q} : {16'h0000, ram_rdata}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop && ce),
    .out_data(fifo_out_data)
  );

  // host side of the data FIFO; one cycle of lag on ready
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_rdata <= '0;
      half_out_q <= 1'b0;
      data_fifo_ready_n <= 1'b1;
    end else if (ce) begin
      data_fifo_ready_n <= !fifo_out_valid || fifo_flush;
      // the last word is still handed over in the cycle whose end flushes the fifo
      if (host_rd && busy_q && fifo_out_valid)
        host_rdata <= half_out_q ? fifo_out_data[31:16] : fifo_out_data[15:0];
      if (fifo_flush || start_in) half_out_q <= 1'b0;
      else if (host_rd && busy_q && fifo_out_valid) half_out_q <= !half_out_q;
    end
  end

  // packet FIFO from the host data port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_wr_q <= '0;
      pkt_rd_q <= '0;
      pfne_q <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        pkt_wr_q <= '0;
        pkt_rd_q <= '0;
        pfne_q <= 1'b0;
      end else begin
        if (host_pkt_wr && pkt_wr_q != `PKT_DEPTH) begin
          pkt_mem_q[pkt_wr_q] <= host_pkt_data;
          pkt_wr_q <= pkt_wr_q + 4'h1;
        end
        if (rd_pkt && pkt_rd_q != pkt_wr_q) pkt_rd_q <= pkt_rd_q + 4'h1;
        if (host_pkt_wr) pfne_q <= 1'b1;
        else if (rd_pkt && pkt_rd_q + 4'h1 == pkt_wr_q) pfne_q <= 1'b0;
        if (!host_pkt_wr && rd_pkt && pkt_rd_q + 4'h1 == pkt_wr_q) begin
          pkt_wr_q <= '0; // drained: rearm for the next packet
          pkt_rd_q <= '0;
        end
      end
    end
  end

  // sector-ready, host command and subcode flags; set beats clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_q <= 1'b0;
      hci_q <= 1'b0;
      sci_q <= 1'b0;
      sub_prev_q <= '0;
    end else if (ce) begin
      sub_prev_q <= subcode_status_reg;
      if (sector_ready_remap ? |target_search_status : sector_ready_evt) sr_q <= 1'b1;
      else if (rd_sec) sr_q <= 1'b0;
      if (|(host_evt & host_evt_en)) hci_q <= 1'b1;
      else if (rd_irq) hci_q <= 1'b0;
      if (subcode_irq_enable && |(subcode_status_reg & ~sub_prev_q)) sci_q <= 1'b1;
      else if (subcode_acknowledge) sci_q <= 1'b0;
    end
  end

  // header capture: Q time wins; otherwise header or subheader bytes as subheader_switch selects
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) head_q <= '0;
    else if (ce) begin
      if (q_channel_time_load) begin
        if (q_in.valid && q_in.idx != 2'd3) head_q[8*q_in.idx +: 8] <= q_in.data;
      end else if (hdr_in.valid && hdr_in.sub == subheader_switch)
        head_q[8*hdr_in.idx +: 8] <= hdr_in.data;
    end
  end

  // buffering and correction addresses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bia_q <= '0;
      eia_q <= '0;
      bac_q <= '0;
      buf_wr_addr <= '0;
      buf_block <= '0;
      ecc_block <= '0;
    end else if (ce) begin
      if (reg_wr && hit(reg_addr, `OFS_BIA_LO)) bia_q[7:0] <= reg_wdata;
      if (reg_wr && hit(reg_addr, `OFS_BIA_HI)) bia_q[15:8] <= reg_wdata;
      if (data_sync) begin
        eia_q <= bia_q;
        bac_q <= bia_q;
      end else begin
        if (reg_wr && hit(reg_addr, `OFS_EIA_WR_LO)) eia_q[7:0] <= reg_wdata;
        if (reg_wr && hit(reg_addr, `OFS_EIA_WR_HI)) eia_q[15:8] <= reg_wdata;
        if (buffer_word) bac_q <= bac_q + `BUF_STEP;
      end
      buf_wr_addr <= bac_q - `BUF_SYNC_OFS;
      buf_block <= decoder_block_number + 16'h0001;
      ecc_block <= decoder_block_number;
    end
  end

  // control zero and plain status outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      decoder_control_zero <= `DECODER_CONTROL_ZERO_RST;
      ram_port_blocked <= 1'b0;
      transfer_busy_flag_n <= 1'b1;
      transfer_end_flag_n <= 1'b1;
      packet_full_flag <= 1'b0;
      transfer_direction_flag <= 1'b0;
      micro_irq_pin_n <= 1'b1;
    end else if (ce) begin
      if (any_rst) decoder_control_zero <= `DECODER_CONTROL_ZERO_RST;
      else if (reg_wr && hit(reg_addr, `OFS_DECODER_CONTROL_ZERO)) decoder_control_zero <= reg_wdata;
      ram_port_blocked <= linear_q;
      transfer_busy_flag_n <= !busy_q;
      transfer_end_flag_n <= !tend_q;
      packet_full_flag <= pkt_wr_q == `PKT_DEPTH;
      transfer_direction_flag <= cause_q != END_PACKET;
      micro_irq_pin_n <= !((pfne_q && interrupt_enable_control_q[`BIT_PFNE_EN]) || (tend_q && interrupt_enable_control_q[`BIT_TEND_EN])
                           || (sr_q && interrupt_enable_control_q[`BIT_SR_EN]));
    end
  end

  // read data path
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= '0;
    else if (ce && reg_rd) begin
      case (reg_addr)
        `OFS_PKT_PORT: reg_rdata <= (pkt_rd_q != pkt_wr_q) ? pkt_mem_q[pkt_rd_q] : `PKT_EMPTY_VAL;
        `OFS_IRQ: reg_rdata <= {!pfne_q, !tend_q, !sr_q, !hci_q, !busy_q, 1'b1,
                                data_fifo_ready_n, !sci_q};
        `OFS_TWC_LO: reg_rdata <= twc_q[7:0];
        `OFS_TWC_HI: reg_rdata <= {linear_q, 3'b000, twc_q[11:8]};
        8'h04, 8'h05, 8'h06, `OFS_HEAD3: reg_rdata <= head_q[8*reg_addr[1:0] +: 8];
        `OFS_EIA_RD_LO: reg_rdata <= eia_q[7:0];
        `OFS_EIA_RD_HI: reg_rdata <= eia_q[15:8];
        `OFS_BAC_LO: reg_rdata <= bac_q[7:0];
        `OFS_BAC_HI: reg_rdata <= bac_q[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence trig_s;
    ce && start_in;
  endsequence
  sequence ack_s;
    ce && wr_transfer_end_acknowledge && !din_pend_q && !(data_in_end || data_out_end || pkt_full_evt);
  endsequence

  irq_pin_track_a: assert property (ce && tend_q && interrupt_enable_control_q[`BIT_TEND_EN] ##1 ce
    |-> !micro_irq_pin_n) else $error("enabled transfer end did not drive pin");
  sr_clear_read_a: assert property (ce && rd_sec && !sector_ready_evt && !sector_ready_remap
    |=> !sr_q) else $error("sector status read kept flag");
  transfer_end_acknowledge_release_a: assert property (ack_s |=> !tend_q)
    else $error("acknowledge did not release end flag");
  busy_on_trig_a: assert property (trig_s |=> busy_q ##1 (!transfer_busy_flag_n || !ce))
    else $error("trigger did not set busy");
  abort_flush_a: assert property (ce && !transfer_logic_enable && !auto_transfer_trigger
    |=> !fifo_out_valid && fst_q == FETCH_IDLE)
    else $error("disable did not abort transfer");
  bac_step_a: assert property (ce && buffer_word && !data_sync |=> bac_q == $past(bac_q) + 16'h0002)
    else $error("buffering counter step wrong");
  eia_copy_a: assert property (ce && data_sync |=> eia_q == $past(bia_q))
    else $error("sync did not copy initial address");
  decoder_control_zero_clear_a: assert property (ce && any_rst |=> decoder_control_zero == 8'h00)
    else $error("control zero not cleared");
  transfer_logic_enable_auto_a: assert property (ce && auto_transfer_trigger && !soft_rst |=> transfer_logic_enable)
    else $error("auto trigger did not enable transfer");
  twc_dec_a: assert property (ce && host_rd && busy_q && twc_q != 12'h000 && !soft_rst
    |=> twc_q == $past(twc_q) - 12'h001) else $error("word counter not decremented");
endmodule // host_transfer_irq_regs
`default_nettype wire

// ---- ram_responder.sv ----
// behavioural external RAM answering the fetch requests of the transfer logic
`timescale 1ns/1ps
`default_nettype none
module ram_responder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ram_rd_req,
  input wire logic [31:0] ram_addr,
  output logic ram_rd_valid,
  output logic [15:0] ram_rdata
);
  logic [1:0] pend_q;
  logic [15:0] word_q;
  // two-cycle answer, word equals the low address bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 2'h0;
      word_q <= 16'h0000;
    end else begin
      pend_q <= {pend_q[0], ram_rd_req};
      if (ram_rd_req) word_q <= ram_addr[15:0];
    end
  end
  assign ram_rd_valid = pend_q[1];
  // inverted outside the valid cycle so a late capture cannot match
  assign ram_rdata = ram_rd_valid ? word_q : ~word_q;
endmodule // ram_responder
`default_nettype wire

// ---- host_transfer_irq_regs_tb_top.sv ----
// self-checking bench for the host transfer and interrupt reason registers
`timescale 1ns/1ps
`default_nettype none
`include "host_xfer_defs.svh"
module host_transfer_irq_regs_tb_top;
  import host_xfer_pkg::*;
  logic clk, sys_rst, ce, host_rst, fw_rst, decoder_rst, reg_wr, reg_rd, host_pkt_wr, host_rd;
  logic host_wr, host_cmd_a0, drive_selected, auto_packet_enable, auto_transfer_trigger;
  logic data_out_direction, data_fifo_reset, sector_ready_remap, sector_ready_evt;
  logic subcode_irq_enable, subcode_acknowledge, subheader_switch, q_channel_time_load;
  logic data_sync, buffer_word, ram_rd_valid, ram_rd_req, ram_port_blocked;
  logic data_fifo_ready_n, transfer_busy_flag_n, transfer_end_flag_n, packet_full_flag;
  logic transfer_direction_flag, micro_irq_pin_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, host_pkt_data, decoder_control_zero;
  logic [6:0] target_search_status;
  logic [2:0] subcode_status_reg;
  logic [15:0] host_rdata, linear_ram_address_counter, transfer_block_number, ram_rdata;
  logic [15:0] decoder_block_number, buf_wr_addr, buf_block, ecc_block;
  logic [31:0] ram_addr;
  host_evt_t host_evt, host_evt_en;
  hdr_byte_t hdr_in, q_in;
  logic [7:0] stat_ofs [3] = '{`OFS_SEC_STAT, `OFS_LSEC_STAT, `OFS_TGT_STAT};
  int fail_count = 0;
  int total_checks = 0;
  host_transfer_irq_regs #(.BLOCK_BYTES(2048), .FIFO_DEPTH(8)) i_host_transfer_irq_regs (.*);
  ram_responder i_ram_responder (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle register strobes, settled one step after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, far beyond the under two hundred cycles of the sequence
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, ce} = 2'b11;
    {host_rst, fw_rst, decoder_rst, reg_wr, reg_rd, host_pkt_wr, host_rd, host_wr} = '0;
    {host_cmd_a0, drive_selected, auto_packet_enable, auto_transfer_trigger} = '0;
    {data_out_direction, data_fifo_reset, sector_ready_remap, sector_ready_evt} = '0;
    {subcode_irq_enable, subcode_acknowledge, subheader_switch, q_channel_time_load} = '0;
    {data_sync, buffer_word, reg_addr, reg_wdata, host_pkt_data} = '0;
    {target_search_status, subcode_status_reg, linear_ram_address_counter} = '0;
    {decoder_block_number, host_evt, host_evt_en, hdr_in, q_in} = '0;
    transfer_block_number = 16'h0003;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`OFS_IRQ);
    chk({8'h00, reg_rdata}, 16'h00FF);
    wr(`OFS_DECODER_CONTROL_ZERO, 8'h5A);
    @(posedge clk);
    decoder_rst <= 1'b1;
    @(posedge clk);
    decoder_rst <= 1'b0;
    #1 chk({8'h00, decoder_control_zero}, 16'h0000);
    // each status read must release the sector-ready request
    wr(`OFS_IRQ, 8'h20);
    foreach (stat_ofs[i]) begin
      @(posedge clk);
      sector_ready_evt <= 1'b1;
      @(posedge clk);
      sector_ready_evt <= 1'b0;
      repeat (3) @(posedge clk);
      chk({15'h0, micro_irq_pin_n}, 16'h0000);
      rd(stat_ofs[i]);
      repeat (2) @(posedge clk);
      chk({15'h0, micro_irq_pin_n}, 16'h0001);
    end
    wr(`OFS_IRQ, 8'h80);
    @(posedge clk);
    host_pkt_data <= 8'hA0;
    host_pkt_wr <= 1'b1;
    @(posedge clk);
    host_pkt_wr <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0, micro_irq_pin_n}, 16'h0000);
    rd(`OFS_PKT_PORT);
    chk({8'h00, reg_rdata}, 16'h00A0);
    rd(`OFS_PKT_PORT);
    chk({8'h00, reg_rdata}, 16'h00FF);
    repeat (2) @(posedge clk);
    chk({15'h0, micro_irq_pin_n}, 16'h0001);
    // two-word block-offset transfer from block 3, offset 10h
    wr(`OFS_IRQ, 8'h42);
    wr(`OFS_TWC_LO, 8'h01);
    wr(`OFS_TWC_HI, 8'h00);
    wr(`OFS_TAC_LO, 8'h10);
    wr(`OFS_TAC_HI, 8'h00);
    wr(`OFS_TRIGGER, 8'h00);
    for (int n = 0; n < 60 && data_fifo_ready_n !== 1'b0; n++) @(posedge clk);
    chk({15'h0, data_fifo_ready_n}, 16'h0000);
    chk({15'h0, transfer_busy_flag_n}, 16'h0000);
    for (int w = 0; w < 2; w++) begin
      @(posedge clk);
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
      #1 chk(host_rdata, 16'h1810 + 16'(2 * w));
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    chk({13'h0, transfer_end_flag_n, transfer_busy_flag_n, micro_irq_pin_n}, 16'h0002);
    wr(`OFS_TRANSFER_END_ACKNOWLEDGE, 8'h00);
    repeat (2) @(posedge clk);
    chk({15'h0, transfer_end_flag_n}, 16'h0000);
    wr(`OFS_DIN_ACK, 8'h00);
    wr(`OFS_TRANSFER_END_ACKNOWLEDGE, 8'h00);
    repeat (2) @(posedge clk);
    chk({14'h0, transfer_end_flag_n, micro_irq_pin_n}, 16'h0003);
    // one-word linear transfer started by the auto trigger with transfer enable off
    wr(`OFS_IRQ, 8'h40);
    wr(`OFS_TWC_LO, 8'h00);
    wr(`OFS_TWC_HI, 8'h80);
    @(posedge clk);
    linear_ram_address_counter <= 16'h0400;
    auto_transfer_trigger <= 1'b1;
    @(posedge clk);
    auto_transfer_trigger <= 1'b0;
    for (int n = 0; n < 60 && data_fifo_ready_n !== 1'b0; n++) @(posedge clk);
    chk({14'h0, transfer_busy_flag_n, ram_port_blocked}, 16'h0001);
    @(posedge clk);
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1 chk(host_rdata, 16'h0400);
    repeat (3) @(posedge clk);
    chk({14'h0, transfer_end_flag_n, transfer_busy_flag_n}, 16'h0001);
    wr(`OFS_DIN_ACK, 8'h00);
    wr(`OFS_TRANSFER_END_ACKNOWLEDGE, 8'h00);
    // remapped sector ready, host command and subcode flags in the reason byte
    @(posedge clk);
    {sector_ready_remap, sector_ready_evt, subcode_irq_enable} <= 3'b111;
    subcode_status_reg <= 3'b100;
    host_evt <= 5'h12;
    host_evt_en <= 5'h02;
    @(posedge clk);
    sector_ready_evt <= 1'b0;
    host_evt <= 5'h00;
    rd(`OFS_IRQ);
    chk({8'h00, reg_rdata}, 16'h00EE);
    @(posedge clk);
    target_search_status <= 7'h04;
    subcode_acknowledge <= 1'b1;
    @(posedge clk);
    target_search_status <= 7'h00;
    subcode_acknowledge <= 1'b0;
    rd(`OFS_IRQ);
    chk({8'h00, reg_rdata}, 16'h00DF);
    // buffering start address copied at sync, then one word buffered
    wr(`OFS_BIA_LO, 8'hFC);
    wr(`OFS_BIA_HI, 8'hFF);
    @(posedge clk);
    data_sync <= 1'b1;
    decoder_block_number <= 16'h0005;
    @(posedge clk);
    data_sync <= 1'b0;
    buffer_word <= 1'b1;
    @(posedge clk);
    buffer_word <= 1'b0;
    repeat (2) @(posedge clk);
    chk(buf_wr_addr, 16'hFFF2);
    chk(buf_block, 16'h0006);
    chk(ecc_block, 16'h0005);
    rd(`OFS_EIA_RD_LO);
    chk({8'h00, reg_rdata}, 16'h00FC);
    // Q time bytes win over header bytes arriving in the same cycle
    @(posedge clk);
    q_channel_time_load <= 1'b1;
    q_in <= {1'b1, 1'b0, 2'h2, 8'h33};
    hdr_in <= {1'b1, 1'b0, 2'h2, 8'h77};
    @(posedge clk);
    q_in <= '0;
    hdr_in <= '0;
    rd(`OFS_HEAD0 + 8'h02);
    chk({8'h00, reg_rdata}, 16'h0033);
    tally_and_finish();
  end
endmodule // host_transfer_irq_regs_tb_top
`default_nettype wire
